// [rtl/ctrb_defs.vh]
// register offsets, field layout, reset values and fuse-load timing for the trim bank
// assumes inclusion by the bank module only; plain Verilog-2005
//
// Overview of operation
// [R01] core A phase-90 input B offset applied
// [R02] core B input A offset applied
// [R03] core B input B offset applied
// [R04] core A bank 0/1 fine gain
// [R05] core B bank 0/1 fine gain
// [R06] defaults loaded from fuse storage
// [R07] software keeps reserved bits zero
`ifndef CTRB_DEFS_VH
`define CTRB_DEFS_VH

// ****************************************
// register indices (printed offsets, byte address = 4 x index)
// ****************************************
`define CTRB_IDX_A_OFS_B90    12'h34A
`define CTRB_IDX_B_OFS_A      12'h34C
`define CTRB_IDX_B_OFS_B      12'h34E
`define CTRB_IDX_A0_GAIN      12'h350
`define CTRB_IDX_A1_GAIN      12'h351
`define CTRB_IDX_B0_GAIN      12'h352
`define CTRB_IDX_B1_GAIN      12'h353
`define CTRB_IDX_CTRL         12'h360
`define CTRB_IDX_STATUS       12'h361

// ****************************************
// fields and reset values
// ****************************************
`define CTRB_OFS_MSB          11
`define CTRB_GAIN_MSB         4
`define CTRB_OFS_RST          16'h0000
`define CTRB_GAIN_RST         8'h00
`define CTRB_CTRL_FGCAL_BIT   0
`define CTRB_CTRL_DUAL_BIT    1
`define CTRB_CTRL_RELOAD_BIT  2
`define CTRB_FUSE_WAIT_NS     40
`define CTRB_CLK_NS           10

`endif

// [rtl/ctrb_trim_bank.v]
// trim register bank: offset and fine gain trims with fuse-loaded defaults
// assumes a single AHB-Lite master, one clock, fuse words stable on fuse_* inputs
`include "ctrb_defs.vh"

module ctrb_trim_bank
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [15:0] fuse_a_ofs_b90,
	input  wire [15:0] fuse_b_ofs_a,
	input  wire [15:0] fuse_b_ofs_b,
	input  wire [31:0] fuse_gain,
	input  wire        core_a_phase90_input_b,
	input  wire        core_b_input_a,
	input  wire        core_b_input_b,
	output reg  [11:0] core_a_offset_trim,
	output reg  [11:0] core_b_offset_trim,
	output reg  [4:0]  core_a_bank0_gain_trim,
	output reg  [4:0]  core_a_bank1_gain_trim,
	output reg  [4:0]  core_b_bank0_gain_trim,
	output reg  [4:0]  core_b_bank1_gain_trim
);

	// fuse settle time rounded up to whole clocks; busy clears when the counter reaches this value, and the counter ends one past it
	localparam integer FUSE_CYC_I = (`CTRB_FUSE_WAIT_NS + `CTRB_CLK_NS - 1) / `CTRB_CLK_NS;
	localparam [2:0]   FUSE_CYC   = FUSE_CYC_I[2:0];

	// ****************************************
	// storage
	// ****************************************
	reg  [15:0] core_a_offset_input_b_phase90;
	reg  [15:0] core_b_offset_input_a;
	reg  [15:0] core_b_offset_input_b;
	wire [31:0] gain_bus;
	reg  [2:0]  ctrl;
	reg  [2:0]  fuse_cnt;
	reg         fuse_busy;
	reg         wr_pend;
	reg  [11:0] wr_idx;
	reg  [31:0] next_rdata;
	wire        addr_ok = hsel && hready && htrans[1];
	wire [11:0] a_idx   = haddr[13:2];
	wire        do_wr   = wr_pend && !fuse_busy;
	wire        cal_on  = ctrl[`CTRB_CTRL_FGCAL_BIT];
	wire        dual_on = ctrl[`CTRB_CTRL_DUAL_BIT];

	// ****************************************
	// fuse copy sequencer
	// ****************************************
	// fuse copy runs after reset and on reload request; bus writes wait behind it
	// reload is honoured only while idle, so a set and a clear never meet [R06]
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fuse_busy <= 1'b1;
			fuse_cnt  <= 3'h0;
		end
		else if (fuse_busy)
		begin
			fuse_cnt  <= fuse_cnt + 3'h1;
			if (fuse_cnt == FUSE_CYC)
				fuse_busy <= 1'b0;
		end
		else if (do_wr && wr_idx == `CTRB_IDX_CTRL && hwdata[`CTRB_CTRL_RELOAD_BIT])
		begin
			fuse_busy <= 1'b1;
			fuse_cnt  <= 3'h0;
		end
	end

	// ****************************************
	// offset and control registers
	// ****************************************
	// register writes; fuse contents overwrite the zero reset value [R06]
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_a_offset_input_b_phase90 <= `CTRB_OFS_RST;
			core_b_offset_input_a         <= `CTRB_OFS_RST;
			core_b_offset_input_b         <= `CTRB_OFS_RST;
			ctrl <= 3'h0;
		end
		else if (fuse_busy)
		begin
			core_a_offset_input_b_phase90 <= fuse_a_ofs_b90; // [R06]
			core_b_offset_input_a         <= fuse_b_ofs_a;
			core_b_offset_input_b         <= fuse_b_ofs_b;
		end
		else if (do_wr)
		begin
			// offset fields stored whole, reserved bits kept as written [R07]; ctrl keeps hwdata bits 1:0 only
			case (wr_idx)
			`CTRB_IDX_A_OFS_B90: core_a_offset_input_b_phase90 <= hwdata[15:0]; // [R01]
			`CTRB_IDX_B_OFS_A:   core_b_offset_input_a <= hwdata[15:0]; // [R02]
			`CTRB_IDX_B_OFS_B:   core_b_offset_input_b <= hwdata[15:0]; // [R03]
			`CTRB_IDX_CTRL:      ctrl <= {1'b0, hwdata[1:0]};
			default:             ctrl <= ctrl;
			endcase
		end
	end

	// ****************************************
	// fine gain bytes, one per core bank
	// ****************************************
	// each byte is its own register so a bank can be trimmed alone [R04] [R05]
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_gain
			localparam integer IDX_I = `CTRB_IDX_A0_GAIN + gi;
			localparam [11:0]  IDX   = IDX_I[11:0];
			reg        [7:0]   val;

			// fuse byte replaces the zero reset value while the copy runs [R06]
			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					val <= `CTRB_GAIN_RST;
				else if (fuse_busy)
					val <= fuse_gain[8*gi +: 8];
				else if (do_wr && wr_idx == IDX)
					val <= hwdata[7:0]; // reserved bits kept as written [R07]
			end

			assign gain_bus[8*gi +: 8] = val;
		end
	endgenerate

	// ****************************************
	// read path
	// ****************************************
	// read mux; unmapped reads return zero
	always @*
	begin
		case (a_idx)
		`CTRB_IDX_A_OFS_B90: next_rdata = {16'h0000, core_a_offset_input_b_phase90};
		`CTRB_IDX_B_OFS_A:   next_rdata = {16'h0000, core_b_offset_input_a};
		`CTRB_IDX_B_OFS_B:   next_rdata = {16'h0000, core_b_offset_input_b};
		`CTRB_IDX_A0_GAIN:   next_rdata = {24'h000000, gain_bus[7:0]};
		`CTRB_IDX_A1_GAIN:   next_rdata = {24'h000000, gain_bus[15:8]};
		`CTRB_IDX_B0_GAIN:   next_rdata = {24'h000000, gain_bus[23:16]};
		`CTRB_IDX_B1_GAIN:   next_rdata = {24'h000000, gain_bus[31:24]};
		`CTRB_IDX_CTRL:      next_rdata = {29'h00000000, ctrl};
		`CTRB_IDX_STATUS:    next_rdata = {31'h00000000, fuse_busy};
		default:             next_rdata = 32'h00000000;
		endcase
	end

	// ****************************************
	// bus slave
	// ****************************************
	// bus slave: reads take no wait state, writes take one, and a write stalls further while fuse copy runs
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_idx    <= 12'h000;
		end
		else if (wr_pend)
		begin
			if (!fuse_busy)
			begin
				wr_pend   <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
		else if (addr_ok)
		begin
			hrdata    <= hwrite ? 32'h00000000 : next_rdata;
			wr_pend   <= hwrite;
			wr_idx    <= a_idx;
			hreadyout <= !hwrite;
		end
		else
			hreadyout <= 1'b1;
	end

	// ****************************************
	// trim steering
	// ****************************************
	// trims steered to the cores only while foreground calibration is on
	// core b input a wins when both inputs are flagged in the same cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			core_a_offset_trim     <= 12'h000;
			core_b_offset_trim     <= 12'h000;
			core_a_bank0_gain_trim <= 5'h00;
			core_a_bank1_gain_trim <= 5'h00;
			core_b_bank0_gain_trim <= 5'h00;
			core_b_bank1_gain_trim <= 5'h00;
		end
		else
		begin
			core_a_offset_trim <= (cal_on && core_a_phase90_input_b) ?
				core_a_offset_input_b_phase90[11:0] : 12'h000; // [R01]
			core_b_offset_trim <= !cal_on ? 12'h000 :
				core_b_input_a ? core_b_offset_input_a[11:0] : // [R02]
				core_b_input_b ? core_b_offset_input_b[11:0] : 12'h000; // [R03]
			core_a_bank0_gain_trim <= (cal_on && dual_on) ? gain_bus[4:0] : 5'h00; // [R04]
			core_a_bank1_gain_trim <= (cal_on && dual_on) ? gain_bus[12:8] : 5'h00; // [R04]
			core_b_bank0_gain_trim <= (cal_on && dual_on) ? gain_bus[20:16] : 5'h00; // [R05]
			core_b_bank1_gain_trim <= (cal_on && dual_on) ? gain_bus[28:24] : 5'h00; // [R05]
		end
	end

endmodule

// [verif/ctrb_trim_bank_checker.sv]
// checker: port-level properties of the trim bank
// assumes a bind onto ctrb_trim_bank and a single clock domain
module ctrb_chk
(
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic        hready,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hreadyout,
	input logic        hresp,
	input logic        core_a_phase90_input_b,
	input logic        core_b_input_a,
	input logic        core_b_input_b,
	input logic [11:0] core_a_offset_trim,
	input logic [11:0] core_b_offset_trim,
	input logic [4:0]  core_a_bank0_gain_trim,
	input logic [4:0]  core_a_bank1_gain_trim,
	input logic [4:0]  core_b_bank0_gain_trim,
	input logic [4:0]  core_b_bank1_gain_trim
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rq = hsel && hready && htrans[1];
	// offsets vanish one cycle after their core stops sampling
	AST_A_IDLE: assert property (!core_a_phase90_input_b |=> core_a_offset_trim == 12'h000)
		else $error("core a offset without sampling");
	AST_B_IDLE: assert property (!core_b_input_a && !core_b_input_b |=> core_b_offset_trim == 12'h000)
		else $error("core b offset without sampling");
	// two cycles on the fuse values have landed, so only the reset of the mode bits keeps these at zero
	AST_GA_RST: assert property ($rose(hresetn) |-> ##2 (core_a_bank0_gain_trim | core_a_bank1_gain_trim) == 5'h00)
		else $error("core a gain not clear after reset");
	AST_GB_RST: assert property ($rose(hresetn) |-> ##2 (core_b_bank0_gain_trim | core_b_bank1_gain_trim) == 5'h00)
		else $error("core b gain not clear after reset");
	// reads never stall, even while fuse copy runs; writes always wait
	AST_RD_ZW: assert property (rq && !hwrite |=> hreadyout)
		else $error("read stalled");
	AST_WR_WAIT: assert property (rq && hwrite |=> !hreadyout)
		else $error("write not stalled");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("error response");
	cover property (core_a_offset_trim != 12'h000);
	cover property (core_b_offset_trim != 12'h000);
	cover property (core_b_bank1_gain_trim != 5'h00);
endmodule
bind ctrb_trim_bank ctrb_chk u_chk
(
	.hclk                   (hclk),
	.hresetn                (hresetn),
	.hsel                   (hsel),
	.hready                 (hready),
	.htrans                 (htrans),
	.hwrite                 (hwrite),
	.hreadyout              (hreadyout),
	.hresp                  (hresp),
	.core_a_phase90_input_b (core_a_phase90_input_b),
	.core_b_input_a         (core_b_input_a),
	.core_b_input_b         (core_b_input_b),
	.core_a_offset_trim     (core_a_offset_trim),
	.core_b_offset_trim     (core_b_offset_trim),
	.core_a_bank0_gain_trim (core_a_bank0_gain_trim),
	.core_a_bank1_gain_trim (core_a_bank1_gain_trim),
	.core_b_bank0_gain_trim (core_b_bank0_gain_trim),
	.core_b_bank1_gain_trim (core_b_bank1_gain_trim)
);

// [verif/tb.sv]
// bench: drives the trim bank over AHB-Lite and checks trims at its ports
// assumes the bound checker; fuse inputs are static
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic        core_a_phase90_input_b = 0, core_b_input_a = 0, core_b_input_b = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, fuse_gain = 32'h04030201;
	logic [15:0] fuse_a_ofs_b90 = 16'h0123, fuse_b_ofs_a = 16'h0456, fuse_b_ofs_b = 16'h0789;
	logic [11:0] core_a_offset_trim, core_b_offset_trim;
	logic [4:0]  core_a_bank0_gain_trim, core_a_bank1_gain_trim;
	logic [4:0]  core_b_bank0_gain_trim, core_b_bank1_gain_trim;
	wire         hready = hreadyout;
	int          mismatches = 0, comparisons = 0;
	// rows: byte address, fuse default, value written
	logic [15:0] row [7][3] = '{'{16'hD28, 16'h0123, 16'h0ABC}, '{16'hD30, 16'h0456, 16'h0F01},
		'{16'hD38, 16'h0789, 16'h0555}, '{16'hD40, 16'h0001, 16'h001F},
		'{16'hD44, 16'h0002, 16'h0011}, '{16'hD48, 16'h0003, 16'h000A},
		'{16'hD4C, 16'h0004, 16'h0015}};
	ctrb_trim_bank dut
	(
		.hclk                   (hclk),
		.hresetn                (hresetn),
		.hsel                   (hsel),
		.haddr                  (haddr),
		.htrans                 (htrans),
		.hwrite                 (hwrite),
		.hsize                  (hsize),
		.hwdata                 (hwdata),
		.hready                 (hready),
		.hrdata                 (hrdata),
		.hreadyout              (hreadyout),
		.hresp                  (hresp),
		.fuse_a_ofs_b90         (fuse_a_ofs_b90),
		.fuse_b_ofs_a           (fuse_b_ofs_a),
		.fuse_b_ofs_b           (fuse_b_ofs_b),
		.fuse_gain              (fuse_gain),
		.core_a_phase90_input_b (core_a_phase90_input_b),
		.core_b_input_a         (core_b_input_a),
		.core_b_input_b         (core_b_input_b),
		.core_a_offset_trim     (core_a_offset_trim),
		.core_b_offset_trim     (core_b_offset_trim),
		.core_a_bank0_gain_trim (core_a_bank0_gain_trim),
		.core_a_bank1_gain_trim (core_a_bank1_gain_trim),
		.core_b_bank0_gain_trim (core_b_bank0_gain_trim),
		.core_b_bank1_gain_trim (core_b_bank1_gain_trim)
	);
	always #5 hclk = ~hclk;
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// bounded wait for hready, sampled at the edge
	task automatic wait_rdy;
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hready !== 1'b1 && k < 40);
		if (k >= 40)
		begin
			mismatches++;
			wrap_up;
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	// poll the busy flag of the fuse copy
	task automatic settle;
		repeat (20)
		begin
			bus(1'b0, 32'h0000_0D84, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		chk(rd, 32'h0);
	endtask
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		settle;
		foreach (row[i])
		begin
			bus(1'b0, row[i][0], 32'h0);
			chk(rd, row[i][1]);
			bus(1'b1, row[i][0], row[i][2]);
			bus(1'b0, row[i][0], 32'h0);
			chk(rd, row[i][2]);
		end
		bus(1'b1, 32'h0000_0D00, 32'h5A5A);
		bus(1'b0, 32'h0000_0D00, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'h0000_0D80, 32'h3);
		core_a_phase90_input_b <= 1'b1;
		core_b_input_a <= 1'b1;
		core_b_input_b <= 1'b1;
		repeat (2) @(posedge hclk);
		chk(core_a_offset_trim, 32'hABC);
		chk(core_b_offset_trim, 32'hF01);
		chk({core_a_bank1_gain_trim, core_a_bank0_gain_trim}, {5'h11, 5'h1F});
		chk({core_b_bank1_gain_trim, core_b_bank0_gain_trim}, {5'h15, 5'h0A});
		core_b_input_a <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(core_b_offset_trim, 32'h555);
		bus(1'b1, 32'h0000_0D80, 32'h0);
		repeat (2) @(posedge hclk);
		chk({core_a_offset_trim, core_b_offset_trim}, 32'h0);
		bus(1'b1, 32'h0000_0D80, 32'h4);
		settle;
		bus(1'b0, 32'h0000_0D28, 32'h0);
		chk(rd, 32'h0123);
		// calibration on, dual mode off: offsets pass, core a bank 0 and core b bank 1 gains stay at zero
		bus(1'b1, 32'h0000_0D80, 32'h1);
		repeat (2) @(posedge hclk);
		chk({core_a_offset_trim, core_b_offset_trim}, 32'h00123789);
		chk({core_a_bank0_gain_trim, core_b_bank1_gain_trim}, 32'h0);
		// mid-run reset, then a write issued while the fuse copy still runs
		hresetn <= 1'b0;
		@(posedge hclk);
		chk({hreadyout, core_a_offset_trim, core_b_offset_trim}, 32'h01000000);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, 32'h0000_0D44, 32'h0007);
		bus(1'b0, 32'h0000_0D44, 32'h0);
		chk(rd, 32'h0007);
		bus(1'b0, 32'h0000_0D40, 32'h0);
		chk(rd, 32'h0001);
		chk({core_a_offset_trim, core_a_bank1_gain_trim}, 32'h0);
		wrap_up;
	end
endmodule
